/* abs_encoder_model.sv */
// Behavioural serial absolute encoder answering the block's serial clock.
`timescale 1ns/1ps
module abs_encoder_model (
	input  wire logic        clk,
	input  wire logic        ser_clk,
	input  wire logic [23:0] word,
	output logic             ser_data
);
	int          idle = 0;
	int          idx = 0;
	logic        clk_prev = 1'b1;
	logic [23:0] frame = 24'h000000;
	// A long idle marks a new frame; the word is frozen so a change never tears a frame.
	// Each bit moves one clock after a fall of the serial clock, well before the rise.
	// After the last bit the line is released and shows the inverse of what it held.
	always @(posedge clk) begin
		clk_prev <= ser_clk;
		idle     <= ser_clk ? idle + 1 : 0;
		if (clk_prev && !ser_clk && idle > 30) begin
			frame    <= word;
			idx      <= 23;
			ser_data <= word[23];
		end else if (clk_prev && !ser_clk && idx > 0) begin
			idx      <= idx - 1;
			ser_data <= frame[idx-1];
		end else if (idx == 0 && idle == 3) begin
			ser_data <= ~ser_data;
		end
	end
endmodule : abs_encoder_model

/* encoder_index_capture_clear.sv */
// Encoder index clear/capture block with serial absolute encoder revolution handling.
//
// Summary of operation
// - Index event from index input by sensitivity: level, to-active, to-inactive, both edges.
// - Ignore-quadrature setting removes A/B polarity qualification of the index event.
// - Reload plus repeat mode overwrites the encoder position on every index event.
// - Single-shot mode without repeat acts on the next index event only, then clears itself.
// - Capture-on-index copies encoder position into the read-only encoder capture register.
// - Capture plus capture-step copies actual step position into the step capture register.
// - Revolution reception off after reset; when on, the field is an unsigned count.
// - Revolution-signed setting makes the received field a two's-complement count.
// - Without reception, derive-revolutions tracks turns from successive angle samples.
// - Derived turns hold only while consecutive samples differ by under half a turn.
// - Encoder position is in microsteps, each absolute position (turns and angle) scaled by the writable encoder scale register.
// - The block drives the serial clock that starts each absolute encoder transfer.
`timescale 1ns/1ps
module encoder_index_capture_clear (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_index,
	input  wire logic        step_pulse,
	input  wire logic        step_dir,
	input  wire logic        ser_data,
	output logic             ser_clk
);
	import encoder_index_pkg::*;

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	typedef struct packed {
		setup_t               setup;
		logic [31:0]          step_pos;
		logic [31:0]          step_cap;
		logic [31:0]          enc_pos;
		logic [31:0]          reload;
		logic [31:0]          enc_cap;
		logic [31:0]          scale;
		logic [31:0]          turns;
		logic [ANGLE_W-1:0]   prev_angle;
		logic                 angle_seen;
		ser_state_t           ser_state;
		logic [TIMER_W-1:0]   timer;
		logic [4:0]           bit_cnt;
		logic [SER_BITS-1:0]  shift;
		logic                 ser_clk;
		logic [1:0]           quad_prev;
		logic [31:0]          rdata;
	} state_t;

	state_t   state_reg;
	state_t   state_next;
	reg_req_t req;
	logic     index_event;

	// Combinational scratch values.
	logic                act;
	logic                frame_done;
	logic [ANGLE_W-1:0]  angle;
	logic [TURN_W-1:0]   turn_field;
	logic [31:0]         turns_new;
	logic [31:0]         abs_pos;
	logic signed [63:0]  product;
	logic [1:0]          quad_now;

	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;

	assign reg_rdata = state_reg.rdata;
	assign ser_clk   = state_reg.ser_clk;

	index_event_detect u_index (
		.clk         (clk),
		.rst         (rst),
		.setup       (state_reg.setup),
		.index_in    (enc_index),
		.quad_a      (enc_a),
		.quad_b      (enc_b),
		.index_event (index_event)
	);

	function automatic logic [31:0] read_mux(input state_t s, input logic [7:0] a);
		case (a)
			ADDR_ENCODER_SETUP_WORD:   read_mux = s.setup;
			ADDR_ACTUAL_STEP_POSITION: read_mux = s.step_pos;
			ADDR_STEP_POSITION_CAPT:   read_mux = s.step_cap;
			ADDR_ENCODER_POSITION:     read_mux = s.enc_pos;
			ADDR_RELOAD_AND_CAPTURE:   read_mux = s.enc_cap;
			ADDR_ENCODER_SCALE:        read_mux = s.scale;
			ADDR_REVOLUTION_COUNT:     read_mux = s.turns;
			default:                   read_mux = 32'h0000_0000;
		endcase
	endfunction : read_mux

	always_comb begin
		state_next = state_reg;
		quad_now   = {enc_a, enc_b};
		frame_done = 1'b0;
		angle      = state_reg.shift[ANGLE_W-1:0];
		turn_field = state_reg.shift[SER_BITS-1:ANGLE_W];
		turns_new  = state_reg.turns;
		abs_pos    = 32'h0000_0000;
		product    = 64'sh0;

		// ------------------------------------------------------------------
		// Internal step position follows the step pulses of the ramp side
		// ------------------------------------------------------------------
		if (step_pulse) begin
			state_next.step_pos = step_dir ? state_reg.step_pos + 32'h0000_0001
			                               : state_reg.step_pos - 32'h0000_0001;
		end

		// ------------------------------------------------------------------
		// Incremental counting, one microstep per valid quadrature transition
		// ------------------------------------------------------------------
		state_next.quad_prev = quad_now;
		if (!state_reg.setup.serial_mode && ^(state_reg.quad_prev ^ quad_now)) begin
			state_next.enc_pos = (state_reg.quad_prev[1] ^ quad_now[0])
				? state_reg.enc_pos + 32'h0000_0001
				: state_reg.enc_pos - 32'h0000_0001;
		end

		// ------------------------------------------------------------------
		// Serial clock generator and receiver
		// ------------------------------------------------------------------
		// The line idles high; a falling edge starts a transfer and data is
		// taken on each rising edge, most significant bit first.
		case (state_reg.ser_state)
			SER_PAUSE: begin
				state_next.ser_clk = 1'b1;
				if (!state_reg.setup.serial_mode) begin
					state_next.timer = '0;
				end else if (state_reg.timer >= TIMER_W'(SER_PAUSE_CYCLES - 1)) begin
					state_next.timer     = '0;
					state_next.bit_cnt   = '0;
					state_next.ser_clk   = 1'b0;
					state_next.ser_state = SER_CLOCK;
				end else begin
					state_next.timer = state_reg.timer + TIMER_W'(1);
				end
			end
			SER_CLOCK: begin
				if (state_reg.timer >= TIMER_W'(SER_HALF_CYCLES - 1)) begin
					state_next.timer   = '0;
					state_next.ser_clk = !state_reg.ser_clk;
					if (!state_reg.ser_clk) begin
						state_next.shift   = {state_reg.shift[SER_BITS-2:0], ser_data};
						state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
					end else if (state_reg.bit_cnt == 5'(SER_BITS)) begin
						state_next.ser_clk   = 1'b1;
						state_next.ser_state = SER_PAUSE;
						frame_done           = 1'b1;
					end
				end else begin
					state_next.timer = state_reg.timer + TIMER_W'(1);
				end
			end
			default: begin
				state_next.ser_state = SER_PAUSE;
				state_next.ser_clk   = 1'b1;
				state_next.timer     = '0;
			end
		endcase

		// ------------------------------------------------------------------
		// Revolution handling and angle scaling at the end of a frame
		// ------------------------------------------------------------------
		if (frame_done && state_reg.setup.serial_mode) begin
			if (state_reg.setup.revolution_enable) begin
				turns_new = state_reg.setup.revolution_signed
					? {{(32-TURN_W){turn_field[TURN_W-1]}}, turn_field}
					: {{(32-TURN_W){1'b0}}, turn_field};
			end else if (state_reg.setup.derive_revolutions && state_reg.angle_seen) begin
				// A jump of half a turn or more cannot be told from a wrap the
				// other way, so the count is only right for slower motion.
				if (angle < state_reg.prev_angle &&
				    (state_reg.prev_angle - angle) > HALF_TURN) begin
					turns_new = state_reg.turns + 32'h0000_0001;
				end else if (angle > state_reg.prev_angle &&
				             (angle - state_reg.prev_angle) > HALF_TURN) begin
					turns_new = state_reg.turns - 32'h0000_0001;
				end
			end else if (!state_reg.setup.derive_revolutions) begin
				turns_new = 32'h0000_0000;
			end
			abs_pos = {turns_new[31-ANGLE_W:0], angle};
			product = $signed(abs_pos) * $signed(state_reg.scale);
			state_next.turns      = turns_new;
			state_next.prev_angle = angle;
			state_next.angle_seen = 1'b1;
			state_next.enc_pos    = product[SCALE_FRAC_BITS+31:SCALE_FRAC_BITS];
		end

		// ------------------------------------------------------------------
		// Index actions
		// ------------------------------------------------------------------
		act = index_event && (state_reg.setup.repeat_on_index ||
		                      state_reg.setup.single_shot_on_index);
		if (act) begin
			if (state_reg.setup.capture_on_index) begin
				state_next.enc_cap = state_reg.enc_pos;
				if (state_reg.setup.capture_step_on_index) begin
					state_next.step_cap = state_reg.step_pos;
				end
			end
			if (state_reg.setup.reload_on_index) begin
				state_next.enc_pos = state_reg.reload;
			end
			if (!state_reg.setup.repeat_on_index) begin
				state_next.setup.single_shot_on_index = 1'b0;
			end
		end

		// ------------------------------------------------------------------
		// Register writes; a software write in the same cycle wins
		// ------------------------------------------------------------------
		if (req.wr) begin
			case (req.addr)
				ADDR_ENCODER_SETUP_WORD:   state_next.setup    = req.wdata;
				ADDR_ACTUAL_STEP_POSITION: state_next.step_pos = req.wdata;
				ADDR_ENCODER_POSITION:     state_next.enc_pos  = req.wdata;
				ADDR_RELOAD_AND_CAPTURE:   state_next.reload   = req.wdata;
				ADDR_ENCODER_SCALE:        state_next.scale    = req.wdata;
				default: begin
				end
			endcase
		end

		state_next.rdata = req.rd ? read_mux(state_reg, req.addr) : 32'h0000_0000;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg           <= '0;
			state_reg.setup     <= REG_RESET_VALUE;
			state_reg.scale     <= SCALE_RESET_VALUE;
			state_reg.ser_state <= SER_PAUSE;
			state_reg.ser_clk   <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : encoder_index_capture_clear

/* encoder_index_pkg.sv */
// Shared constants, register map and types for the encoder index capture/clear block.
package encoder_index_pkg;

	// ----------------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADDR_ENCODER_SETUP_WORD   = 8'h07;
	localparam logic [7:0] ADDR_ACTUAL_STEP_POSITION = 8'h21;
	localparam logic [7:0] ADDR_STEP_POSITION_CAPT   = 8'h36;
	localparam logic [7:0] ADDR_ENCODER_POSITION     = 8'h50;
	localparam logic [7:0] ADDR_RELOAD_AND_CAPTURE   = 8'h51;
	localparam logic [7:0] ADDR_ENCODER_SCALE        = 8'h54;
	localparam logic [7:0] ADDR_REVOLUTION_COUNT     = 8'h55;

	localparam logic [31:0] REG_RESET_VALUE   = 32'h0000_0000;
	// Scale is 16.16 fixed point; one microstep per angle unit after reset.
	localparam logic [31:0] SCALE_RESET_VALUE = 32'h0001_0000;
	localparam int          SCALE_FRAC_BITS   = 16;

	// ----------------------------------------------------------------------
	// Serial absolute encoder frame
	// ----------------------------------------------------------------------
	localparam int ANGLE_W  = 12;
	localparam int TURN_W   = 12;
	localparam int SER_BITS = ANGLE_W + TURN_W;
	localparam logic [ANGLE_W-1:0] HALF_TURN = 12'h800;

	localparam int CLK_PERIOD_NS     = 50;
	localparam int SER_HALF_NS       = 500;
	localparam int SER_PAUSE_NS      = 21000;
	localparam int SER_HALF_CYCLES   = SER_HALF_NS / CLK_PERIOD_NS;
	localparam int SER_PAUSE_CYCLES  = (SER_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W           = 9;

	// ----------------------------------------------------------------------
	// Setup word layout, bit 0 first from the right
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		SENSE_LEVEL    = 2'h0,
		SENSE_TO_ACT   = 2'h1,
		SENSE_TO_INACT = 2'h2,
		SENSE_BOTH     = 2'h3
	} index_sense_t;

	typedef struct packed {
		logic [16:0]  unused;
		logic         serial_mode;
		logic         derive_revolutions;
		logic         revolution_signed;
		logic         revolution_enable;
		logic         capture_step_on_index;
		logic         capture_on_index;
		logic         single_shot_on_index;
		logic         repeat_on_index;
		logic         reload_on_index;
		index_sense_t index_sensitivity;
		logic         ignore_quadrature_gate;
		logic         pol_index;
		logic         pol_b_for_index;
		logic         pol_a_for_index;
	} setup_t;

	typedef enum logic [1:0] {
		SER_PAUSE = 2'b01,
		SER_CLOCK = 2'b10
	} ser_state_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage : encoder_index_pkg

/* encoder_index_properties.sv */
// Port-level properties of the encoder index capture/clear block.
`timescale 1ns/1ps
module encoder_index_properties
	import encoder_index_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        step_pulse,
	input wire logic        ser_clk
);
	logic [9:0] hi_cnt;
	logic [4:0] nfall;
	logic       ser_prev;
	// Counts falls since the last long idle so frame length and pause can be judged.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= 10'h000;
			nfall <= 5'h00;
			ser_prev <= 1'b1;
		end else begin
			hi_cnt <= !ser_clk ? 10'h000 : (hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001;
			ser_prev <= ser_clk;
			if (ser_prev && !ser_clk)
				nfall <= (hi_cnt > 10'h064) ? 5'h01 : nfall + 5'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_read_one_cycle;
		!$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
	endproperty
	a_read_one_cycle: assert property (p_read_one_cycle) else $error("stale read data");
	property p_unmapped_zero;
		reg_rd && !(reg_addr inside {8'h07, 8'h21, 8'h36, 8'h50, 8'h51, 8'h54, 8'h55})
			|=> reg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_setup_back;
		reg_wr && reg_addr == ADDR_ENCODER_SETUP_WORD ##1 !reg_wr ##1
			reg_rd && reg_addr == ADDR_ENCODER_SETUP_WORD
			|=> (reg_rdata & 32'h0000_7EFF) == ($past(reg_wdata, 3) & 32'h0000_7EFF);
	endproperty
	a_setup_back: assert property (p_setup_back) else $error("setup word readback wrong");
	property p_step_back;
		reg_wr && reg_addr == ADDR_ACTUAL_STEP_POSITION && !step_pulse ##1 !step_pulse ##1
			reg_rd && reg_addr == ADDR_ACTUAL_STEP_POSITION && !step_pulse
			|=> reg_rdata == $past(reg_wdata, 3);
	endproperty
	a_step_back: assert property (p_step_back) else $error("step position readback wrong");
	property p_low_phase;
		$fell(ser_clk) |-> (!ser_clk) [*8] ##1 (!ser_clk) [*2] ##1 ser_clk;
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("serial clock low phase wrong");
	property p_high_phase;
		$rose(ser_clk) |-> ser_clk [*8] ##1 ser_clk;
	endproperty
	a_high_phase: assert property (p_high_phase) else $error("short clock high");
	property p_frame_bits;
		$fell(ser_clk) && nfall != 5'h00 && nfall < 5'h18 |-> hi_cnt == 10'h00A;
	endproperty
	a_frame_bits: assert property (p_frame_bits) else $error("serial frame cut short");
	property p_pause;
		$fell(ser_clk) && nfall == 5'h18 |-> hi_cnt >= 10'h1A3;
	endproperty
	a_pause: assert property (p_pause) else $error("serial pause too short");
endmodule : encoder_index_properties

bind encoder_index_capture_clear encoder_index_properties u_props (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .step_pulse(step_pulse), .ser_clk(ser_clk));

/* index_event_detect.sv */
// Index event detector with sensitivity selection and quadrature qualification.
`timescale 1ns/1ps
module index_event_detect (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire encoder_index_pkg::setup_t setup,
	input  wire logic                      index_in,
	input  wire logic                      quad_a,
	input  wire logic                      quad_b,
	output logic                           index_event
);
	import encoder_index_pkg::*;

	typedef struct packed {
		logic index_prev;
	} det_state_t;

	det_state_t state_reg;
	det_state_t state_next;
	logic       act_now;
	logic       act_prev;
	logic       quad_ok;
	logic       raw_event;

	function automatic logic level_fits(input logic level, input logic pol);
		level_fits = (level == pol);
	endfunction : level_fits

	always_comb begin
		state_next            = state_reg;
		state_next.index_prev = index_in;
		act_now  = level_fits(index_in, setup.pol_index);
		act_prev = level_fits(state_reg.index_prev, setup.pol_index);
		case (setup.index_sensitivity)
			SENSE_LEVEL:    raw_event = act_now;
			SENSE_TO_ACT:   raw_event = act_now && !act_prev;
			SENSE_TO_INACT: raw_event = !act_now && act_prev;
			SENSE_BOTH:     raw_event = act_now != act_prev;
			default:        raw_event = 1'b0;
		endcase
		quad_ok = setup.ignore_quadrature_gate ||
			(level_fits(quad_a, setup.pol_a_for_index) &&
			 level_fits(quad_b, setup.pol_b_for_index));
		index_event = raw_event && quad_ok;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : index_event_detect

/* tb_top.sv */
// Self-checking testbench for the encoder index capture/clear block.
`timescale 1ns/1ps
module tb_top;
	import encoder_index_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        enc_a = 1'b0;
	logic        enc_b = 1'b0;
	logic        enc_index = 1'b0;
	logic        step_pulse = 1'b0;
	logic        step_dir = 1'b1;
	logic        ser_data;
	logic        ser_clk;
	logic [23:0] enc_word = 24'h000000;
	int          miscompares = 0;
	int          n_compared = 0;
	always #25 clk = ~clk;
	encoder_index_capture_clear u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .step_pulse(step_pulse),
		.step_dir(step_dir), .ser_data(ser_data), .ser_clk(ser_clk));
	abs_encoder_model u_enc (.clk(clk), .ser_clk(ser_clk), .word(enc_word), .ser_data(ser_data));
	// ----------------------------------------------------------------------
	// Bus and index helpers
	// ----------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(what, reg_rdata, exp);
	endtask : rdc
	task automatic idx_set(input logic v);
		@(posedge clk);
		enc_index <= v;
		repeat (2) @(posedge clk);
	endtask : idx_set
	task automatic pulse;
		idx_set(1'b1);
		idx_set(1'b0);
	endtask : pulse
	task automatic t_reset;
		logic [7:0] a[7] = '{8'h07, 8'h21, 8'h36, 8'h50, 8'h51, 8'h55, 8'h99};
		foreach (a[i]) rdc("reset value", a[i], 32'h0);
		rdc("scale reset", ADDR_ENCODER_SCALE, SCALE_RESET_VALUE);
		$display("test reset done");
	endtask : t_reset
	task automatic t_sense;
		logic [31:0] cfg;
		logic [31:0] prev;
		prev = 32'h0;
		for (int m = 0; m < 4; m++) begin
			cfg = 32'h0000_028C | (32'(m) << 4);
			wr(ADDR_ENCODER_SETUP_WORD, cfg);
			rdc("setup readback", ADDR_ENCODER_SETUP_WORD, cfg);
			wr(ADDR_ENCODER_POSITION, 32'h10 + 32'(m));
			idx_set(1'b1);
			rdc("capture rise", ADDR_RELOAD_AND_CAPTURE, (m == 2) ? prev : 32'h10 + 32'(m));
			wr(ADDR_ENCODER_POSITION, 32'h20 + 32'(m));
			idx_set(1'b0);
			prev = (m == 1) ? 32'h11 : 32'h20 + 32'(m);
			rdc("capture fall", ADDR_RELOAD_AND_CAPTURE, prev);
		end
		$display("test sensitivity done");
	endtask : t_sense
	task automatic t_reload;
		wr(ADDR_RELOAD_AND_CAPTURE, 32'h0000_1234);
		wr(ADDR_ENCODER_POSITION, 32'h0000_0077);
		wr(ADDR_ENCODER_SETUP_WORD, 32'h0000_02DC);
		for (int k = 0; k < 2; k++) begin
			pulse;
			rdc("reloaded position", ADDR_ENCODER_POSITION, 32'h0000_1234);
			rdc("pre-reload capture", ADDR_RELOAD_AND_CAPTURE, k ? 32'h55 : 32'h77);
			wr(ADDR_ENCODER_POSITION, 32'h0000_0055);
		end
		$display("test reload done");
	endtask : t_reload
	task automatic t_single;
		wr(ADDR_ACTUAL_STEP_POSITION, 32'h0000_0100);
		rdc("step position", ADDR_ACTUAL_STEP_POSITION, 32'h0000_0100);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			step_dir <= (k != 3);
			step_pulse <= 1'b1;
			@(posedge clk);
			step_pulse <= 1'b0;
		end
		wr(ADDR_ENCODER_POSITION, 32'h0000_000A);
		wr(ADDR_ENCODER_SETUP_WORD, 32'h0000_071C);
		for (int k = 0; k < 2; k++) begin
			pulse;
			rdc("step capture", ADDR_STEP_POSITION_CAPT, 32'h0000_0102);
			rdc("encoder capture", ADDR_RELOAD_AND_CAPTURE, 32'h0000_000A);
			rdc("single shot cleared", ADDR_ENCODER_SETUP_WORD, 32'h0000_061C);
			wr(ADDR_ACTUAL_STEP_POSITION, 32'h0000_0200);
			wr(ADDR_ENCODER_POSITION, 32'h0000_000B);
			wr(ADDR_STEP_POSITION_CAPT, 32'h0000_FFFF);
		end
		$display("test single shot done");
	endtask : t_single
	task automatic t_quad;
		wr(ADDR_ENCODER_SETUP_WORD, 32'h0000_0297);
		wr(ADDR_ENCODER_POSITION, 32'h0000_0031);
		pulse;
		rdc("gated capture", ADDR_RELOAD_AND_CAPTURE, 32'h0000_000A);
		@(posedge clk);
		enc_a <= 1'b1;
		enc_b <= 1'b1;
		pulse;
		rdc("qualified capture", ADDR_RELOAD_AND_CAPTURE, 32'h0000_0031);
		wr(ADDR_ENCODER_SETUP_WORD, 32'h0000_029C);
		wr(ADDR_ENCODER_POSITION, 32'h0000_0033);
		pulse;
		rdc("ignored gate capture", ADDR_RELOAD_AND_CAPTURE, 32'h0000_0033);
		$display("test quadrature gate done");
	endtask : t_quad
	task automatic t_serial;
		logic [31:0] cfg[6] = '{32'h6000, 32'h6000, 32'h6000, 32'h4800, 32'h5800, 32'h4800};
		logic [23:0] w[6] = '{24'h000D00, 24'h000300, 24'h000900, 24'h002123, 24'hFFF100, 24'h002123};
		logic [31:0] pos[6] = '{32'hD00, 32'h1300, 32'h1900, 32'h2123, 32'hFFFF_F100, 32'h4246};
		logic [31:0] rev[6] = '{32'h0, 32'h1, 32'h1, 32'h2, 32'hFFFF_FFFF, 32'h2};
		for (int i = 0; i < 6; i++) begin
			if (i == 5) wr(ADDR_ENCODER_SCALE, 32'h0002_0000);
			wr(ADDR_ENCODER_SETUP_WORD, cfg[i]);
			enc_word <= w[i];
			repeat (2000) @(posedge clk);
			rdc("serial position", ADDR_ENCODER_POSITION, pos[i]);
			rdc("revolutions", ADDR_REVOLUTION_COUNT, rev[i]);
		end
		$display("test serial done");
	endtask : t_serial
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_sense;
		t_reload;
		t_single;
		t_quad;
		t_serial;
		end_sim;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim;
	end
endmodule : tb_top
